// ---- src/cisd_pkg.sv ----
package cisd_pkg;

    // Values after reset
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam logic [31:0] RESET_SP = 32'h0000_1000;

    // Special register selectors of the move-special instructions
    localparam logic [7:0] SYS_FLAGS = 8'h00;
    localparam logic [7:0] SYS_MAIN_SP = 8'h08;
    localparam logic [7:0] SYS_PROC_SP = 8'h09;
    localparam logic [7:0] SYS_PRIO_MASK = 8'h10;
    localparam logic [7:0] SYS_CONTROL = 8'h14;

    // Register indices and field positions
    localparam logic [3:0] IDX_SP = 4'hD;
    localparam logic [3:0] IDX_LR = 4'hE;
    localparam logic [3:0] IDX_PC = 4'hF;
    localparam int CTRL_SPSEL = 1;
    localparam int FLAG_N_POS = 31;
    localparam int FLAG_Z_POS = 30;

    // Address steps
    localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
    localparam logic [31:0] HALF_STEP = 32'h0000_0002;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // Access sizes on the data bus
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [3:0] {
        OP_UNDEF, OP_MEM, OP_PUSH, OP_POP, OP_TEST, OP_MOVI,
        OP_RSPEC, OP_WSPEC, OP_BX, OP_BLX, OP_BL
    } cisd_op_t;

    typedef enum logic [2:0] {ST_FETCH, ST_FETCH2, ST_EXEC, ST_MEM, ST_FAULT} cisd_st_t;

    typedef struct packed {
        cisd_op_t op;
        logic mem_we;
        logic [1:0] mem_size;
        logic mem_sext;
        logic use_rm;
        logic [3:0] rt;
        logic [3:0] rn;
        logic [3:0] rm;
        logic [31:0] imm;
        logic [15:0] list;
        logic [7:0] sysm;
    } cisd_dec_t;

    typedef struct packed {
        cisd_st_t st;
        logic [31:0] pc;
        logic [31:0] iaddr;
        logic [15:0] hw1;
        logic [15:0] hw2;
        logic [12:0][31:0] gpr;
        logic [31:0] lr;
        logic [31:0] main_stack_pointer;
        logic [31:0] process_stack_pointer;
        logic irq_priority_mask;
        logic [1:0] control;
        logic flag_n;
        logic flag_z;
        logic [15:0] list;
        logic [31:0] maddr;
        logic mwe;
        logic [1:0] msize;
        logic msext;
        logic sp_upd;
        logic [31:0] sp_final;
        logic imem_req;
        logic dbus_req;
        logic [31:0] dbus_wdata;
        logic fault;
        logic retire;
    } cisd_state_t;

    // First halfword of a two-halfword instruction
    function automatic logic is_wide(input logic [15:0] hw);
        return (hw[15:11] == 5'h1D) || (hw[15:11] == 5'h1E) || (hw[15:11] == 5'h1F);
    endfunction

endpackage

// ---- src/cisd_decode.sv ----
`timescale 1ns/1ns
module cisd_decode (
    // Instruction halfwords
    input wire logic [15:0] hw1,
    input wire logic [15:0] hw2,
    // Decoded fields
    output cisd_pkg::cisd_dec_t dec
);
    logic s;
    logic i1;
    logic i2;

    // Pattern match on the opcode fields; unknown codes fall to OP_UNDEF
    always_comb begin
        dec = '0;
        dec.op = cisd_pkg::OP_UNDEF;
        dec.mem_size = cisd_pkg::SIZE_WORD;
        s = hw1[10];
        i1 = ~(hw2[13] ^ s);
        i2 = ~(hw2[11] ^ s);
        if (hw1[15:12] == 4'h5) begin
            dec.op = cisd_pkg::OP_MEM;
            dec.use_rm = 1'b1;
            dec.rm = {1'b0, hw1[8:6]};
            dec.rn = {1'b0, hw1[5:3]};
            dec.rt = {1'b0, hw1[2:0]};
            dec.mem_we = ~hw1[11] & ~(hw1[10] & hw1[9]);
            unique case (hw1[11:9])
                3'h0, 3'h4: dec.mem_size = cisd_pkg::SIZE_WORD;
                3'h1, 3'h5, 3'h7: dec.mem_size = cisd_pkg::SIZE_HALF;
                3'h2, 3'h3, 3'h6: dec.mem_size = cisd_pkg::SIZE_BYTE;
            endcase
            dec.mem_sext = (hw1[11:9] == 3'h3) || (hw1[11:9] == 3'h7);
        end else if (hw1[15:13] == 3'h3) begin
            // Immediate offset form, scaled by four for words
            dec.op = cisd_pkg::OP_MEM;
            dec.rn = {1'b0, hw1[5:3]};
            dec.rt = {1'b0, hw1[2:0]};
            dec.mem_we = ~hw1[11];
            dec.mem_size = hw1[12] ? cisd_pkg::SIZE_BYTE : cisd_pkg::SIZE_WORD;
            dec.imm = hw1[12] ? {27'h0, hw1[10:6]} : {25'h0, hw1[10:6], 2'h0};
        end else if (hw1[15:9] == 7'h5A) begin
            dec.op = cisd_pkg::OP_PUSH;
            dec.list = {1'b0, hw1[8], 6'h0, hw1[7:0]};
        end else if (hw1[15:9] == 7'h5E) begin
            dec.op = cisd_pkg::OP_POP;
            dec.list = {hw1[8], 7'h0, hw1[7:0]};
        end else if (hw1[15:6] == 10'h108) begin
            dec.op = cisd_pkg::OP_TEST;
            dec.rn = {1'b0, hw1[2:0]};
            dec.rm = {1'b0, hw1[5:3]};
        end else if (hw1[15:11] == 5'h04) begin
            dec.op = cisd_pkg::OP_MOVI;
            dec.rt = {1'b0, hw1[10:8]};
            dec.imm = {24'h0, hw1[7:0]};
        end else if (hw1[15:8] == 8'h47 && hw1[2:0] == 3'h0) begin
            dec.op = hw1[7] ? cisd_pkg::OP_BLX : cisd_pkg::OP_BX;
            dec.rm = hw1[6:3];
        end else if (hw1[15:4] == 12'hF3E && hw2[15:12] == 4'h8) begin
            dec.op = cisd_pkg::OP_RSPEC;
            dec.rt = hw2[11:8];
            dec.sysm = hw2[7:0];
        end else if (hw1[15:4] == 12'hF38 && hw2[15:8] == 8'h88) begin
            dec.op = cisd_pkg::OP_WSPEC;
            dec.rn = hw1[3:0];
            dec.sysm = hw2[7:0];
        end else if (hw1[15:11] == 5'h1E && hw2[15:14] == 2'h3 && hw2[12]) begin
            dec.op = cisd_pkg::OP_BL;
            dec.imm = {{7{s}}, s, i1, i2, hw1[9:0], hw2[10:0], 1'b0};
        end
    end

endmodule

// ---- src/cisd_core.sv ----
`timescale 1ns/1ns
module cisd_core (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Instruction fetch
    output logic IMEM_REQ,
    output logic [31:0] IMEM_ADDR,
    input wire logic [15:0] IMEM_RDATA,
    input wire logic IMEM_ACK,
    // Data bus
    output logic DBUS_REQ,
    output logic DBUS_WE,
    output logic [1:0] DBUS_SIZE,
    output logic [31:0] DBUS_ADDR,
    output logic [31:0] DBUS_WDATA,
    input wire logic [31:0] DBUS_RDATA,
    input wire logic DBUS_ACK,
    // Status
    output logic RETIRE,
    output logic CORE_FAULT,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic IRQ_MASK
);
    cisd_pkg::cisd_state_t st_r;
    cisd_pkg::cisd_state_t st_nxt;
    cisd_pkg::cisd_dec_t dec;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_val;
    logic [31:0] ea;
    logic [31:0] tst_res;
    logic [31:0] tgt;
    logic [31:0] ld;
    logic [31:0] act_sp;
    logic [31:0] span;
    logic [3:0] ld_idx;
    logic [31:0] src_val;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Register read; r13 follows the selected stack, r15 reads four ahead
    function automatic logic [31:0] rd_reg(input cisd_pkg::cisd_state_t s,
                                           input logic [3:0] i);
        if (i < cisd_pkg::IDX_SP) return s.gpr[i];
        else if (i == cisd_pkg::IDX_SP) return s.control[cisd_pkg::CTRL_SPSEL] ? s.process_stack_pointer : s.main_stack_pointer;
        else if (i == cisd_pkg::IDX_LR) return s.lr;
        else return s.iaddr + cisd_pkg::PC_AHEAD;
    endfunction

    function automatic logic [4:0] popcnt(input logic [15:0] l);
        logic [4:0] c;
        c = 5'h0;
        for (int k = 0; k < 16; k++) c = c + {4'h0, l[k]};
        return c;
    endfunction

    // Lowest listed register goes first, so it lands at the lowest address
    function automatic logic [3:0] lowest(input logic [15:0] l);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 15; k >= 0; k--) if (l[k]) r = k[3:0];
        return r;
    endfunction

    function automatic logic [31:0] ld_ext(input logic [31:0] d, input logic [1:0] sz,
                                           input logic sx);
        if (sz == cisd_pkg::SIZE_BYTE) return sx ? {{24{d[7]}}, d[7:0]} : {24'h0, d[7:0]};
        else if (sz == cisd_pkg::SIZE_HALF) return sx ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
        else return d;
    endfunction

    function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
        return (sz == cisd_pkg::SIZE_HALF && a[0]) || (sz == cisd_pkg::SIZE_WORD && a[1:0] != 2'h0);
    endfunction

    cisd_decode u_decode (
        .hw1(st_r.hw1),
        .hw2(st_r.hw2),
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    assign act_sp = rd_reg(st_r, cisd_pkg::IDX_SP);
    assign ld_idx = lowest(st_r.list);
    // Source of the element on the bus, for the byte store check
    assign src_val = rd_reg(st_r, ld_idx);
    assign span = {25'h0, popcnt(dec.list), 2'h0};

    always_comb begin
        st_nxt = st_r;
        st_nxt.retire = 1'b0;
        wr_en = 1'b0;
        wr_idx = 4'h0;
        wr_val = 32'h0;
        ea = rd_reg(st_r, dec.rn) + (dec.use_rm ? rd_reg(st_r, dec.rm) : dec.imm);
        tst_res = rd_reg(st_r, dec.rn) & rd_reg(st_r, dec.rm);
        tgt = rd_reg(st_r, dec.rm);
        ld = ld_ext(DBUS_RDATA, st_r.msize, st_r.msext);
        unique case (st_r.st)
            cisd_pkg::ST_FETCH: begin
                if (IMEM_ACK) begin
                    st_nxt.hw1 = IMEM_RDATA;
                    st_nxt.hw2 = 16'h0;
                    st_nxt.iaddr = st_r.pc;
                    st_nxt.pc = st_r.pc + cisd_pkg::HALF_STEP;
                    st_nxt.st = cisd_pkg::is_wide(IMEM_RDATA) ? cisd_pkg::ST_FETCH2
                                                               : cisd_pkg::ST_EXEC;
                end
            end
            cisd_pkg::ST_FETCH2: begin
                if (IMEM_ACK) begin
                    st_nxt.hw2 = IMEM_RDATA;
                    st_nxt.pc = st_r.pc + cisd_pkg::HALF_STEP;
                    st_nxt.st = cisd_pkg::ST_EXEC;
                end
            end
            cisd_pkg::ST_EXEC: begin
                st_nxt.st = cisd_pkg::ST_FETCH;
                st_nxt.retire = 1'b1;
                unique case (dec.op)
                    cisd_pkg::OP_MEM: begin
                        // Single access runs as a one-entry list
                        st_nxt.list = 16'h0001 << dec.rt;
                        st_nxt.maddr = ea;
                        st_nxt.mwe = dec.mem_we;
                        st_nxt.msize = dec.mem_size;
                        st_nxt.msext = dec.mem_sext;
                        st_nxt.sp_upd = 1'b0;
                        st_nxt.st = cisd_pkg::ST_MEM;
                        st_nxt.retire = 1'b0;
                        if (misaligned(ea, dec.mem_size)) begin
                            st_nxt.st = cisd_pkg::ST_FAULT;
                            st_nxt.fault = 1'b1;
                        end
                    end
                    cisd_pkg::OP_PUSH, cisd_pkg::OP_POP: begin
                        // Full descending stack; the pointer moves once the list is done
                        st_nxt.list = dec.list;
                        st_nxt.mwe = (dec.op == cisd_pkg::OP_PUSH);
                        st_nxt.maddr = st_nxt.mwe ? act_sp - span : act_sp;
                        st_nxt.sp_final = st_nxt.mwe ? act_sp - span : act_sp + span;
                        st_nxt.msize = cisd_pkg::SIZE_WORD;
                        st_nxt.msext = 1'b0;
                        st_nxt.sp_upd = 1'b1;
                        if (dec.list != 16'h0) begin
                            st_nxt.st = cisd_pkg::ST_MEM;
                            st_nxt.retire = 1'b0;
                        end
                    end
                    cisd_pkg::OP_TEST: begin
                        st_nxt.flag_n = tst_res[31];
                        st_nxt.flag_z = (tst_res == 32'h0);
                    end
                    cisd_pkg::OP_MOVI: begin
                        wr_en = 1'b1;
                        wr_idx = dec.rt;
                        wr_val = dec.imm;
                        st_nxt.flag_n = 1'b0;
                        st_nxt.flag_z = (dec.imm == 32'h0);
                    end
                    cisd_pkg::OP_RSPEC: begin
                        wr_en = 1'b1;
                        wr_idx = dec.rt;
                        unique case (dec.sysm)
                            cisd_pkg::SYS_FLAGS: wr_val = {st_r.flag_n, st_r.flag_z, 30'h0};
                            cisd_pkg::SYS_MAIN_SP: wr_val = st_r.main_stack_pointer;
                            cisd_pkg::SYS_PROC_SP: wr_val = st_r.process_stack_pointer;
                            cisd_pkg::SYS_PRIO_MASK: wr_val = {31'h0, st_r.irq_priority_mask};
                            cisd_pkg::SYS_CONTROL: wr_val = {30'h0, st_r.control};
                            default: wr_val = 32'h0;
                        endcase
                    end
                    cisd_pkg::OP_WSPEC: begin
                        // Stack pointers stay word aligned whatever is written
                        unique case (dec.sysm)
                            cisd_pkg::SYS_FLAGS: begin
                                st_nxt.flag_n = ea[cisd_pkg::FLAG_N_POS];
                                st_nxt.flag_z = ea[cisd_pkg::FLAG_Z_POS];
                            end
                            cisd_pkg::SYS_MAIN_SP: st_nxt.main_stack_pointer = {ea[31:2], 2'h0};
                            cisd_pkg::SYS_PROC_SP: st_nxt.process_stack_pointer = {ea[31:2], 2'h0};
                            cisd_pkg::SYS_PRIO_MASK: st_nxt.irq_priority_mask = ea[0];
                            cisd_pkg::SYS_CONTROL: st_nxt.control = ea[1:0];
                            default: st_nxt.irq_priority_mask = st_r.irq_priority_mask;
                        endcase
                    end
                    cisd_pkg::OP_BX, cisd_pkg::OP_BLX: begin
                        st_nxt.pc = {tgt[31:1], 1'b0};
                        if (dec.op == cisd_pkg::OP_BLX) begin
                            st_nxt.lr = {st_r.pc[31:1], 1'b1};
                        end
                        if (!tgt[0]) begin
                            st_nxt.st = cisd_pkg::ST_FAULT;
                            st_nxt.fault = 1'b1;
                            st_nxt.retire = 1'b0;
                        end
                    end
                    cisd_pkg::OP_BL: begin
                        st_nxt.lr = {st_r.pc[31:1], 1'b1};
                        st_nxt.pc = st_r.pc + dec.imm;
                    end
                    cisd_pkg::OP_UNDEF: begin
                        st_nxt.st = cisd_pkg::ST_FAULT;
                        st_nxt.fault = 1'b1;
                        st_nxt.retire = 1'b0;
                    end
                endcase
            end
            cisd_pkg::ST_MEM: begin
                if (DBUS_ACK) begin
                    if (!st_r.mwe && ld_idx != cisd_pkg::IDX_PC) begin
                        wr_en = 1'b1;
                        wr_idx = ld_idx;
                        wr_val = ld;
                    end
                    st_nxt.list[ld_idx] = 1'b0;
                    st_nxt.maddr = st_r.maddr + cisd_pkg::WORD_STEP;
                    if (st_nxt.list == 16'h0) begin
                        if (st_r.sp_upd && st_r.control[cisd_pkg::CTRL_SPSEL]) begin
                            st_nxt.process_stack_pointer = st_r.sp_final;
                        end else if (st_r.sp_upd) begin
                            st_nxt.main_stack_pointer = st_r.sp_final;
                        end
                        st_nxt.st = cisd_pkg::ST_FETCH;
                        st_nxt.retire = 1'b1;
                    end
                    // Popped PC is taken last; an even address stops the core
                    if (!st_r.mwe && ld_idx == cisd_pkg::IDX_PC) begin
                        st_nxt.pc = {ld[31:1], 1'b0};
                        if (!ld[0]) begin
                            st_nxt.st = cisd_pkg::ST_FAULT;
                            st_nxt.fault = 1'b1;
                            st_nxt.retire = 1'b0;
                        end
                    end
                end
            end
            cisd_pkg::ST_FAULT: st_nxt.st = cisd_pkg::ST_FAULT;
        endcase
        // Single register write port
        if (wr_en && wr_idx < cisd_pkg::IDX_SP) begin
            st_nxt.gpr[wr_idx] = wr_val;
        end else if (wr_en && wr_idx == cisd_pkg::IDX_SP) begin
            if (st_r.control[cisd_pkg::CTRL_SPSEL]) st_nxt.process_stack_pointer = wr_val;
            else st_nxt.main_stack_pointer = wr_val;
        end else if (wr_en && wr_idx == cisd_pkg::IDX_LR) begin
            st_nxt.lr = wr_val;
        end
        // Bus requests held as flops, derived from the coming state
        st_nxt.imem_req = (st_nxt.st == cisd_pkg::ST_FETCH) || (st_nxt.st == cisd_pkg::ST_FETCH2);
        st_nxt.dbus_req = (st_nxt.st == cisd_pkg::ST_MEM);
        st_nxt.dbus_wdata = 32'h0;
        if (st_nxt.st == cisd_pkg::ST_MEM && st_nxt.mwe) begin
            st_nxt.dbus_wdata = rd_reg(st_r, lowest(st_nxt.list));
            if (st_nxt.msize == cisd_pkg::SIZE_BYTE) begin
                st_nxt.dbus_wdata[31:8] = 24'h0;
            end
        end
    end

    // Reset loads constants only
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r <= '0;
            st_r.pc <= cisd_pkg::RESET_PC;
            st_r.main_stack_pointer <= cisd_pkg::RESET_SP;
            st_r.imem_req <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign IMEM_REQ = st_r.imem_req;
    assign IMEM_ADDR = st_r.pc;
    assign DBUS_REQ = st_r.dbus_req;
    assign DBUS_WE = st_r.mwe;
    assign DBUS_SIZE = st_r.msize;
    assign DBUS_ADDR = st_r.maddr;
    assign DBUS_WDATA = st_r.dbus_wdata;
    assign RETIRE = st_r.retire;
    assign CORE_FAULT = st_r.fault;
    assign FLAG_N = st_r.flag_n;
    assign FLAG_Z = st_r.flag_z;
    assign IRQ_MASK = st_r.irq_priority_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_word_load: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (st_r.st == cisd_pkg::ST_MEM && DBUS_ACK && !st_r.mwe && ld_idx < cisd_pkg::IDX_SP
         && st_r.msize == cisd_pkg::SIZE_WORD)
        |=> st_r.gpr[$past(ld_idx)] == $past(DBUS_RDATA))
        else $error("word load not written to register");

    chk_byte_load_ext: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (st_r.st == cisd_pkg::ST_MEM && DBUS_ACK && !st_r.mwe
         && st_r.msize == cisd_pkg::SIZE_BYTE)
        |=> st_r.gpr[$past(ld_idx)] == {{24{$past(st_r.msext) & $past(DBUS_RDATA[7])}},
                                       $past(DBUS_RDATA[7:0])})
        else $error("byte load value or extension wrong");

    chk_store_word: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        DBUS_REQ && DBUS_WE && DBUS_SIZE == cisd_pkg::SIZE_WORD
        |-> DBUS_WDATA == rd_reg(st_r, ld_idx))
        else $error("stored word differs from source");

    chk_store_byte: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        DBUS_REQ && DBUS_WE && DBUS_SIZE == cisd_pkg::SIZE_BYTE
        |-> DBUS_WDATA == {24'h0, src_val[7:0]})
        else $error("byte store carries more than low byte");

    chk_push_start: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r.st == cisd_pkg::ST_EXEC && dec.op == cisd_pkg::OP_PUSH && dec.list != 16'h0
        |=> DBUS_REQ && DBUS_WE && DBUS_ADDR == $past(act_sp) - $past(span))
        else $error("push does not start below stack pointer");

    chk_stack_update: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r.st == cisd_pkg::ST_MEM && DBUS_ACK && st_r.sp_upd && $countones(st_r.list) == 1
        && !(ld_idx == cisd_pkg::IDX_PC && !DBUS_RDATA[0])
        |=> act_sp == $past(st_r.sp_final) && RETIRE)
        else $error("stack pointer not updated at end of list");

    chk_test_flags: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r.st == cisd_pkg::ST_EXEC && dec.op == cisd_pkg::OP_TEST
        |=> FLAG_Z == ($past(tst_res) == 32'h0) && FLAG_N == $past(tst_res[31])
            && st_r.gpr == $past(st_r.gpr))
        else $error("and test flags wrong or register written");

    chk_mask_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r.st == cisd_pkg::ST_EXEC && dec.op == cisd_pkg::OP_WSPEC
        && dec.sysm == cisd_pkg::SYS_PRIO_MASK
        |=> IRQ_MASK == $past(ea[0]) ##1 $stable(IRQ_MASK))
        else $error("priority mask write lost");

    chk_even_target: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r.st == cisd_pkg::ST_EXEC && (dec.op == cisd_pkg::OP_BX || dec.op == cisd_pkg::OP_BLX)
        && !tgt[0]
        |=> CORE_FAULT && !IMEM_REQ ##1 CORE_FAULT)
        else $error("even branch target did not stop the core");

    chk_link_bit: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r.st == cisd_pkg::ST_EXEC && (dec.op == cisd_pkg::OP_BL || dec.op == cisd_pkg::OP_BLX)
        |=> st_r.lr == ($past(st_r.pc) | 32'h0000_0001))
        else $error("link register bit 0 not set");

endmodule

// ---- tb/cisd_mem_model.sv ----
`timescale 1ns/1ns
module cisd_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fetch port
    input wire logic ireq,
    input wire logic [31:0] iaddr,
    output logic [15:0] irdata,
    output logic iack,
    // Data port
    input wire logic dreq,
    input wire logic dwe,
    input wire logic [1:0] dsize,
    input wire logic [31:0] daddr,
    input wire logic [31:0] dwdata,
    output logic [31:0] drdata,
    output logic dack
);
    logic [15:0] imem [0:127];
    logic [7:0] dmem [0:8191];
    logic [65:0] wlog [$];
    logic [1:0] pace = 2'h0;
    wire logic [12:0] a = daddr[12:0];
    initial {irdata, iack, drdata, dack} = '0;
////////////////////////////////
    // Waits vary with pace; idle data toggles so that a stale capture shows
    always @(posedge clk) begin
        pace <= rst_b ? pace + 2'h1 : 2'h0;
        iack <= rst_b && ireq && !iack && pace[0];
        dack <= rst_b && dreq && !dack && pace[1];
        irdata <= (ireq && !iack && pace[0]) ? imem[iaddr[7:1]] : ~irdata;
        drdata <= ~drdata;
        if (dreq && !dack && pace[1] && !dwe) begin
            // Junk above a byte, so a missing zero fill is caught
            drdata <= (dsize == cisd_pkg::SIZE_BYTE) ? {24'hFFFFFF, dmem[a]}
                : {dmem[a + 13'h3], dmem[a + 13'h2], dmem[a + 13'h1], dmem[a]};
        end
        if (dack && dreq && dwe) begin
            wlog.push_back({dsize, daddr, dwdata});
            dmem[a] <= dwdata[7:0];
            if (dsize == cisd_pkg::SIZE_WORD) begin
                {dmem[a + 13'h3], dmem[a + 13'h2], dmem[a + 13'h1]} <= dwdata[31:8];
            end
        end
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic REF_CLK, RST_B, IMEM_REQ, IMEM_ACK, DBUS_REQ, DBUS_WE, DBUS_ACK;
    logic RETIRE, CORE_FAULT, FLAG_N, FLAG_Z, IRQ_MASK;
    logic [1:0] DBUS_SIZE;
    logic [15:0] IMEM_RDATA;
    logic [31:0] IMEM_ADDR, DBUS_ADDR, DBUS_WDATA, DBUS_RDATA;
    int err_total = 0;
    int total_checks = 0;
    // Program; every indirect branch target is odd until the final indirect branch
    logic [15:0] prog [0:35] = '{16'h2085, 16'h2140, 16'h6008, 16'h7048, 16'h784A, 16'h604A,
        16'h688D, 16'h422D, 16'hF3EF, 16'h8600, 16'h60CE, 16'h247A, 16'h4220, 16'hF3EF, 16'h8600,
        16'h610E, 16'h6148, 16'hF380, 16'h8810, 16'hF381, 16'h8809, 16'hF3EF, 16'h8710, 16'h618F,
        16'hF3EF, 16'h8709, 16'h61CF, 16'hF000, 16'hF800, 16'hB505, 16'hBC38, 16'hF3EF, 16'h8008,
        16'h6008, 16'h604D, 16'h4720};
    // Stores expected in order: size, address, data
    logic [65:0] rows [0:12] = '{66'h2_0000_0040_0000_0085, 66'h0_0000_0041_0000_0085,
        66'h2_0000_0044_0000_0085, 66'h2_0000_004C_8000_0000, 66'h2_0000_0050_4000_0000,
        66'h2_0000_0054_0000_0085, 66'h2_0000_0058_0000_0001, 66'h2_0000_005C_0000_0040,
        {2'h2, cisd_pkg::RESET_SP - 32'hC, 32'h85}, {2'h2, cisd_pkg::RESET_SP - 32'h8, 32'h85},
        {2'h2, cisd_pkg::RESET_SP - 32'h4, 32'h3B}, {2'h2, 32'h40, cisd_pkg::RESET_SP},
        66'h2_0000_0044_0000_003B};
////////////////////////////////
    cisd_core cisd_core_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .IMEM_REQ(IMEM_REQ),
        .IMEM_ADDR(IMEM_ADDR), .IMEM_RDATA(IMEM_RDATA), .IMEM_ACK(IMEM_ACK),
        .DBUS_REQ(DBUS_REQ), .DBUS_WE(DBUS_WE), .DBUS_SIZE(DBUS_SIZE), .DBUS_ADDR(DBUS_ADDR),
        .DBUS_WDATA(DBUS_WDATA), .DBUS_RDATA(DBUS_RDATA), .DBUS_ACK(DBUS_ACK), .RETIRE(RETIRE),
        .CORE_FAULT(CORE_FAULT), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .IRQ_MASK(IRQ_MASK));
    cisd_mem_model cisd_mem_model_inst (.clk(REF_CLK), .rst_b(RST_B), .ireq(IMEM_REQ),
        .iaddr(IMEM_ADDR), .irdata(IMEM_RDATA), .iack(IMEM_ACK), .dreq(DBUS_REQ), .dwe(DBUS_WE),
        .dsize(DBUS_SIZE), .daddr(DBUS_ADDR), .dwdata(DBUS_WDATA), .drdata(DBUS_RDATA),
        .dack(DBUS_ACK));
////////////////////////////////
    task automatic check(input logic [65:0] seen, input logic [65:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Free-running clock
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // Generous bound: the program needs a few hundred cycles
    initial begin
        #(5000 * 50);
        err_total++;
        results();
    end
    // Load memories, reset, run, then compare the store log
    initial begin
        RST_B = 1'b0;
        foreach (prog[i]) cisd_mem_model_inst.imem[i] = prog[i];
        cisd_mem_model_inst.imem[66] = 16'h4708;
        {cisd_mem_model_inst.dmem[16'h4B], cisd_mem_model_inst.dmem[16'h4A]} = 16'hF000;
        {cisd_mem_model_inst.dmem[16'h49], cisd_mem_model_inst.dmem[16'h48]} = 16'h0000;
        repeat (12) @(negedge REF_CLK);
        check({IMEM_REQ, IMEM_ADDR, DBUS_REQ, CORE_FAULT}, {1'b1, 32'h0, 2'h0});
        RST_B = 1'b1;
        for (int n = 0; n < 2000 && CORE_FAULT !== 1'b1; n++) @(negedge REF_CLK);
        check({CORE_FAULT, IMEM_REQ, IRQ_MASK}, 3'b101);
        check(66'(cisd_mem_model_inst.wlog.size()), 66'hD);
        foreach (rows[i]) check(cisd_mem_model_inst.wlog[i], rows[i]);
        // A fault holds only until the next reset
        RST_B = 1'b0;
        @(negedge REF_CLK);
        check({IMEM_REQ, IMEM_ADDR, CORE_FAULT}, {1'b1, 32'h0, 1'b0});
        results();
    end
endmodule
